// ===== design/synth_three_wire_load_port.sv
// three-wire programming port: shift register, four load latches, power and output control
// Overview of operation
// - each rising serial clock edge shifts the data pin into a 21-bit shift register.
// - a rising load strobe copies the shift register into the one latch chosen by the two control bits.
// - while chip enable is low the part is powered down and the charge pump output is high impedance.
// - with chip enable high the part powers up only if the programmed power-down bit allows it.
// - the monitor output shows lock detect, divided rf or divided reference as programmed.
// - the fast-lock switch output is programmable to switch in an external loop filter resistor.
`timescale 1ns/1ps
`include "synth_load_params.svh"
module synth_three_wire_load_port
  import synth_load_pkg::*;
#(
  parameter int WORD_BITS   = `SLP_WORD_BITS,
  parameter int LATCH_COUNT = `SLP_LATCH_COUNT
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_serial_clk,
  input  wire logic                 i_serial_data,
  input  wire logic                 i_latch_load_strobe,
  input  wire logic                 i_chip_enable,
  input  wire logic                 i_lock_detect,
  input  wire logic                 i_rf_div,
  input  wire logic                 i_ref_div,
  input  wire logic                 i_pump_drive,
  output logic                      o_charge_pump_out,
  output logic                      o_charge_pump_out_oe,
  output logic                      o_power_down,
  output logic                      o_monitor_select_out,
  output logic                      o_fast_lock_switch_out,
  output logic [LATCH_COUNT*WORD_BITS-1:0] o_latches
);
  initial begin
    if (WORD_BITS != `SLP_WORD_BITS) $error("WORD_BITS must match the documented word length");
    if (LATCH_COUNT != (1 << `SLP_CTRL_BITS)) $error("LATCH_COUNT must equal two to the control width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge finding
  logic [`SLP_SYNC_WIDTH-1:0] pins_s;
  logic                       sclk_d_r;
  logic                       le_d_r;

  pin_sync #(
    .WIDTH (`SLP_SYNC_WIDTH)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_chip_enable, i_latch_load_strobe, i_serial_data, i_serial_clk}),
    .o_sync     (pins_s)
  );

  wire sclk_s    = pins_s[0];
  wire sdata_s   = pins_s[1];
  wire le_s      = pins_s[2];
  wire ce_s      = pins_s[3];
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire le_rise   = le_s & ~le_d_r;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r   <= le_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register; data and clock share the same sync delay so setup holds
  logic [WORD_BITS-1:0] shift_r;
  wire  [WORD_BITS-1:0] shift_nxt = {shift_r[WORD_BITS-2:0], sdata_s}; // msb first

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r <= `SLP_LATCH_RESET;
    end else if (sclk_rise) begin
      shift_r <= shift_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load latches; a strobe in the same cycle as a clock edge takes the older word
  wire [`SLP_CTRL_BITS-1:0] ctrl_sel = shift_r[`SLP_CTRL_BITS-1:0];
  logic [LATCH_COUNT-1:0][WORD_BITS-1:0] latch_r;

  genvar g;
  generate
    for (g = 0; g < LATCH_COUNT; g = g + 1) begin : g_latch
      wire load_hit = le_rise & (ctrl_sel == (`SLP_CTRL_BITS)'(g));
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          latch_r[g] <= `SLP_LATCH_RESET;
        end else if (load_hit) begin
          latch_r[g] <= shift_r; // only a strobe edge writes
        end
      end
    end
  endgenerate
  // one flat assignment keeps a single driver on the port; latch k lands at its k-th word
  assign o_latches = latch_r;

  ////////////////////////////////////////////////////////////////////////////
  // function latch fields
  wire [WORD_BITS-1:0] func_w    = latch_r[`SLP_CTRL_FUNC];
  wire                 pd_bit    = func_w[`SLP_PD_BIT_POS];
  wire mon_sel_t       mon_sel   = func_w[`SLP_MON_SEL_MSB:`SLP_MON_SEL_LSB];
  wire                 fast_bit  = func_w[`SLP_FAST_LOCK_POS];

  ////////////////////////////////////////////////////////////////////////////
  // power control
  pwr_state_t pwr_r;
  wire        up_ok    = ce_s & ~pd_bit;
  pwr_state_t pwr_nxt;

  always_comb begin
    case (pwr_r)
      PWR_DOWN: pwr_nxt = up_ok ? PWR_UP : PWR_DOWN;
      PWR_UP:   pwr_nxt = up_ok ? PWR_UP : PWR_DOWN;
      default:  pwr_nxt = PWR_DOWN;
    endcase
  end

  // monitor mux; the top code, SLP_MON_LOW, gives a quiet low pin when nothing is wanted
  logic mon_nxt;
  always_comb begin
    case (mon_sel)
      `SLP_MON_LOCK:    mon_nxt = i_lock_detect;
      `SLP_MON_RF_DIV:  mon_nxt = i_rf_div;
      `SLP_MON_REF_DIV: mon_nxt = i_ref_div;
      default:          mon_nxt = 1'b0;
    endcase
  end

  wire pwr_up_nxt = (pwr_nxt == PWR_UP);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_r                  <= PWR_DOWN;
      o_power_down           <= 1'b1;
      o_charge_pump_out_oe   <= 1'b0;
      o_charge_pump_out      <= 1'b0;
      o_monitor_select_out   <= 1'b0;
      o_fast_lock_switch_out <= 1'b0;
    end else begin
      pwr_r                  <= pwr_nxt;
      o_power_down           <= ~pwr_up_nxt;
      o_charge_pump_out_oe   <= pwr_up_nxt;                    // high impedance when down
      o_charge_pump_out      <= pwr_up_nxt & i_pump_drive;
      o_monitor_select_out   <= mon_nxt;
      o_fast_lock_switch_out <= fast_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  shift_step_a: assert property (
    sclk_rise |=> shift_r == {$past(shift_r[WORD_BITS-2:0]), $past(sdata_s)})
    else $error("shift register did not take the data bit");

  shift_hold_a: assert property (
    !sclk_rise |=> $stable(shift_r))
    else $error("shift register moved without a clock edge");

  load_pick_a: assert property (
    le_rise |=> latch_r[$past(ctrl_sel)] == $past(shift_r))
    else $error("selected latch did not load the word");

  latch_keep_a: assert property (
    !le_rise |=> $stable(latch_r))
    else $error("latch changed without a load strobe edge");

  pump_tristate_a: assert property (
    !ce_s |=> !o_charge_pump_out_oe && o_power_down)
    else $error("charge pump driven while chip enable low");

  pd_gate_a: assert property (
    ce_s && pd_bit |=> o_power_down && !o_charge_pump_out_oe)
    else $error("powered up against the power-down bit");

  power_up_a: assert property (
    ce_s && !pd_bit |=> !o_power_down ##0 o_charge_pump_out_oe)
    else $error("did not power up when allowed");

  mon_lock_a: assert property (
    mon_sel == `SLP_MON_LOCK |=> o_monitor_select_out == $past(i_lock_detect))
    else $error("monitor does not show lock detect");

  mon_ref_a: assert property (
    mon_sel == `SLP_MON_REF_DIV |=> o_monitor_select_out == $past(i_ref_div))
    else $error("monitor does not show divided reference");

  fast_lock_a: assert property (
    1'b1 |=> o_fast_lock_switch_out == $past(fast_bit))
    else $error("fast-lock output does not follow its bit");

  mon_rf_a: assert property (
    mon_sel == `SLP_MON_RF_DIV |=> o_monitor_select_out == $past(i_rf_div))
    else $error("monitor does not show divided rf");

  mon_low_a: assert property (
    mon_sel == `SLP_MON_LOW |=> !o_monitor_select_out)
    else $error("monitor not low for the quiet code");

  pump_quiet_a: assert property (
    !o_charge_pump_out_oe |-> !o_charge_pump_out)
    else $error("charge pump level set while not driven");

  pump_follow_a: assert property (
    o_charge_pump_out_oe |-> o_charge_pump_out == $past(i_pump_drive))
    else $error("charge pump does not follow its drive");

  func_keep_a: assert property (
    le_rise && ctrl_sel != `SLP_CTRL_FUNC |=> $stable(latch_r[`SLP_CTRL_FUNC]))
    else $error("function latch loaded for another control code");
endmodule

// ===== design/synth_load_params.svh
// constants for the three-wire synthesizer load port
`ifndef SYNTH_LOAD_PARAMS_SVH
`define SYNTH_LOAD_PARAMS_SVH

`define SLP_WORD_BITS      21
`define SLP_CTRL_BITS      2
`define SLP_LATCH_COUNT    4
`define SLP_SYNC_WIDTH     4
// function latch layout, control bits 2'b10
`define SLP_CTRL_FUNC      2'h2
`define SLP_PD_BIT_POS     3
`define SLP_MON_SEL_LSB    4
`define SLP_MON_SEL_MSB    5
`define SLP_FAST_LOCK_POS  6
// latch contents after reset
`define SLP_LATCH_RESET    21'h000000
// monitor selection codes
`define SLP_MON_LOCK       2'h0
`define SLP_MON_RF_DIV     2'h1
`define SLP_MON_REF_DIV    2'h2
`define SLP_MON_LOW        2'h3

`endif

// ===== design/synth_load_pkg.sv
// types shared by the synthesizer load port
package synth_load_pkg;
  typedef logic [1:0] mon_sel_t;
  typedef enum logic [1:0] {
    PWR_DOWN = 2'h1,
    PWR_UP   = 2'h2
  } pwr_state_t;
endpackage

// ===== design/pin_sync.sv
// two-flop synchroniser for pins arriving from outside the core clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic meta_r;
      logic sync_r;
      // the first flop feeds only the second
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= i_async[g];
          sync_r <= meta_r;
        end
      end
      assign o_sync[g] = sync_r;
    end
  endgenerate
endmodule

// ===== sim/host_ctrl_model.sv
// host controller model driving the three-wire programming pins
`timescale 1ns/1ps
module host_ctrl_model (
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_latch_load_strobe
);
  initial begin
    o_serial_clk        = 1'b0;
    o_serial_data       = 1'b0;
    o_latch_load_strobe = 1'b0;
  end
  ////////////////////////////////
  // clock idles low between frames; released data shows the inverse of its last bit
  task automatic send_word(input logic [20:0] word, input bit load);
    for (int i = 20; i >= 0; i--) begin
      o_serial_data = word[i];
      #160 o_serial_clk = 1'b1;
      #160 o_serial_clk = 1'b0;
    end
    o_serial_data = ~word[0];
    #160 o_latch_load_strobe = load;
    #160 o_latch_load_strobe = 1'b0;
    #160;
  endtask
endmodule

// ===== sim/tb_synth_three_wire_load_port.sv
// self-checking bench for the three-wire load port
`timescale 1ns/1ps
`include "synth_load_params.svh"
module tb_synth_three_wire_load_port;
  logic        i_core_clk = 1'b0, i_rst_b = 1'b0, i_chip_enable = 1'b0, i_pump_drive = 1'b0;
  logic        i_lock_detect = 1'b0, i_rf_div = 1'b0, i_ref_div = 1'b0;
  logic        sclk, sdata, strobe, cp, cp_oe, pwr_dn, mon, fls;
  logic [83:0] latches, exp_l;
  int          fail_count = 0, check_count = 0;
  always #20 i_core_clk = ~i_core_clk;
  synth_three_wire_load_port u_synth_three_wire_load_port (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_serial_clk(sclk), .i_serial_data(sdata),
    .i_latch_load_strobe(strobe), .i_chip_enable(i_chip_enable), .i_lock_detect(i_lock_detect),
    .i_rf_div(i_rf_div), .i_ref_div(i_ref_div), .i_pump_drive(i_pump_drive),
    .o_charge_pump_out(cp), .o_charge_pump_out_oe(cp_oe), .o_power_down(pwr_dn),
    .o_monitor_select_out(mon), .o_fast_lock_switch_out(fls), .o_latches(latches));
  host_ctrl_model u_host_ctrl_model (
    .o_serial_clk(sclk), .o_serial_data(sdata), .o_latch_load_strobe(strobe));
  ////////////////////////////////
  task automatic check(string name, logic [83:0] seen, logic [83:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // the load settles within three core edges of the strobe rise, before the strobe falls again
  task automatic send(logic [20:0] w, bit ld);
    u_host_ctrl_model.send_word(w, ld);
    cyc(2);
  endtask
  function automatic logic [20:0] fw(logic fl, logic [1:0] sel, logic pd);
    return {14'h0, fl, sel, pd, 1'b0, `SLP_CTRL_FUNC};
  endfunction
  ////////////////////////////////
  task automatic test_latches();
    logic [20:0] w;
    exp_l = '0;
    for (int k = 0; k < 4; k++) begin
      w = {19'h5a3c1 + 19'(k * 4097), 2'(k)};
      exp_l[21*k +: 21] = w;
      send(w, 1'b1);
      check("latches", latches, exp_l);
    end
    // a full word with no strobe must leave every latch alone
    send(21'h1ffffe, 1'b0);
    check("latches held", latches, exp_l);
  endtask
  task automatic test_power();
    send(fw(1'b0, 2'h0, 1'b0), 1'b1);
    check("down oe", {pwr_dn, cp_oe}, 84'h2);
    i_chip_enable = 1'b1;
    i_pump_drive  = 1'b1;
    cyc(8);
    check("up", {pwr_dn, cp_oe, cp}, 84'h3);
    send(fw(1'b0, 2'h0, 1'b1), 1'b1);
    check("pd bit", {pwr_dn, cp_oe}, 84'h2);
    send(fw(1'b0, 2'h0, 1'b0), 1'b1);
    check("pd clear", {pwr_dn, cp_oe}, 84'h1);
    i_pump_drive = 1'b0;
    cyc(2);
    check("pump low", {cp_oe, cp}, 84'h2);
    i_chip_enable = 1'b0;
    cyc(8);
    check("ce low", {pwr_dn, cp_oe}, 84'h2);
    i_chip_enable = 1'b1;
  endtask
  task automatic test_monitor();
    logic [2:0] p;
    for (int s = 0; s < 4; s++) begin
      send(fw(s[0], 2'(s), 1'b0), 1'b1);
      check("fast lock", fls, s[0]);
      for (int j = 0; j < 2; j++) begin
        p = j ? 3'h2 : 3'h5;
        {i_lock_detect, i_rf_div, i_ref_div} = p;
        cyc(3);
        check("monitor", mon, s == 0 ? p[2] : s == 1 ? p[1] : s == 2 ? p[0] : 1'b0);
      end
    end
  endtask
  ////////////////////////////////
  initial begin
    cyc(2);
    check("reset latches", latches, 84'h0);
    check("reset power", {pwr_dn, cp_oe}, 84'h2);
    cyc(1);
    i_rst_b = 1'b1;
    cyc(2);
    test_latches();
    test_power();
    test_monitor();
    stop_test();
  end
  // bounded run: a hang is counted as a mismatch
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
endmodule
